// ==== verilog/crps_consts.vh ====
// Constants for the clock, reset and pin-state controller.
// Assumes a single 25 MHz ref_clk; included by bare name.
//
// What this block does
// - Clock output is input clock halved, even duty
// - Reset request aborts bus cycle, enters initial state
// - During reset every pin but the clock and crystal outputs takes reset level
// - Reset indicator lags reset request by three ref_clk edges
// - Release realigns clock, fetch starts at 0FFFF0H
// - Reset indicator high in reset, low otherwise
// - Clock and crystal outputs run in all states
// - Crystal output still drives in pin-float mode
// - Address/data pins: address phase then data phase
// - Address/data float in hold, reset and powerdown; powerdown keeps last value
// - Powerdown exit waits delay pin; drive/float it
// - Latch interrupt edge, service type 2
// - Wait instruction stalls until test input low
// - Pin-float mode floats address/data and delay pin, mutes strobe
`ifndef CRPS_CONSTS_VH
`define CRPS_CONSTS_VH

`define CRPS_RESET_VECTOR 20'hFFFF0
`define CRPS_NMI_TYPE 8'h02
`define CRPS_ADDR_W 20
`define CRPS_AD_W 16
`define CRPS_SYNC_STAGES 2
`define CRPS_SYNC_INIT 6'h1C
`define CRPS_PD_SETTLE_NS 1000
`define CRPS_CLK_PERIOD_NS 40
`define CRPS_BUS_8BIT_MASK 16'h00FF

`endif

// ==== verilog/crps_sync.v ====
// Two-stage synchroniser for a group of asynchronous levels.
// Assumes the inputs come from pins outside the ref_clk domain.
`timescale 1ns/1ns
`default_nettype none
module crps_sync #(
    parameter WIDTH = 1,
    parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
    // Clock and reset
    input wire ref_clk,
    input wire rst,
    // Levels
    input wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);
    reg [WIDTH-1:0] meta_r;
    reg [WIDTH-1:0] sync_r;

    // First stage feeds only the second
    always @(posedge ref_clk)
    begin
        if (rst)
        begin
            meta_r <= INIT;
            sync_r <= INIT;
        end
        else
        begin
            meta_r <= async_in;
            sync_r <= meta_r;
        end
    end

    assign sync_out = sync_r;
endmodule // crps_sync
`default_nettype wire

// ==== verilog/crps_edge_latch.v ====
// Sticky edge latch for the non-maskable interrupt.
// Assumes a synchronised, same-clock input level.
`timescale 1ns/1ns
`default_nettype none
module crps_edge_latch (
    // Clock and reset
    input wire ref_clk,
    input wire rst,
    // Event and acknowledge
    input wire level_in,
    input wire ack,
    output wire pending
);
    reg prev_r;
    reg pend_r;
    wire rise;

    assign rise = level_in & ~prev_r;

    always @(posedge ref_clk)
    begin
        if (rst)
        begin
            prev_r <= 1'b0;
            pend_r <= 1'b0;
        end
        else
        begin
            prev_r <= level_in;
            // Set wins over ack so a back-to-back edge is not lost
            pend_r <= rise | (pend_r & ~ack);
        end
    end

    assign pending = pend_r;
endmodule // crps_edge_latch
`default_nettype wire

// ==== verilog/crps_ctrl.v ====
// Clock, reset and pin-state controller for a 16-bit embedded processor.
// Assumes osc_input is the oscillator sampled on ref_clk; the core
// presents bus cycle requests and takes the fetch vector and NMI.
`timescale 1ns/1ns
`default_nettype none
`include "crps_consts.vh"
module crps_ctrl #(
    parameter BUS_8BIT = 0,
    parameter PD_SETTLE_CYC = (`CRPS_PD_SETTLE_NS + `CRPS_CLK_PERIOD_NS - 1)
                              / `CRPS_CLK_PERIOD_NS
) (
    // Clock and reset
    input wire ref_clk,
    input wire rst,
    // Oscillator pins
    input wire osc_input,
    output reg crystal_drive_out,
    output reg half_rate_clock_out,
    // Reset pins
    input wire reset_request_in_n,
    output reg reset_indicator_out,
    // Async pins
    input wire nmi_in,
    input wire wait_test_in_n,
    input wire upper_addr_test_select,
    // Powerdown delay pin
    input wire powerdown_delay_pin_i,
    output reg powerdown_delay_pin_o,
    output reg powerdown_delay_pin_oe,
    // Address/data pins
    input wire [`CRPS_AD_W-1:0] muxed_addr_data_i,
    output reg [`CRPS_AD_W-1:0] muxed_addr_data_o,
    output reg muxed_addr_data_oe,
    output reg addr_latch_strobe,
    // Core side
    input wire bus_hold_req,
    input wire powerdown_req,
    input wire wake_req,
    input wire core_bus_start,
    input wire core_bus_write,
    input wire [`CRPS_ADDR_W-1:0] core_addr,
    input wire [`CRPS_AD_W-1:0] core_wdata,
    input wire core_wait_instr,
    input wire nmi_ack,
    output reg [`CRPS_AD_W-1:0] core_rdata,
    output reg core_bus_done,
    output reg core_run,
    output reg [`CRPS_ADDR_W-1:0] fetch_addr,
    output reg fetch_start,
    output reg nmi_pending,
    output reg [7:0] nmi_type,
    output reg pin_float_test_mode
);
    // ************************************************
    // Synchronisers
    // ************************************************
    localparam SYNC_W = 6;
    wire [SYNC_W-1:0] sync_v;
    wire res_n_s, nmi_s, test_n_s, a19_s, pdt_s;
    wire osc_s;

    // Reset request idles asserted until seen high
    // The oscillator is a pin as well; its two cycles of lag are
    // harmless because it runs far slower than ref_clk
    crps_sync #(.WIDTH(SYNC_W), .INIT(`CRPS_SYNC_INIT)) u_sync (
        .ref_clk(ref_clk),
        .rst(rst),
        .async_in({osc_input, wait_test_in_n, upper_addr_test_select,
                   powerdown_delay_pin_i, nmi_in, reset_request_in_n}),
        .sync_out(sync_v)
    );
    assign res_n_s = sync_v[0];
    assign nmi_s = sync_v[1];
    assign pdt_s = sync_v[2];
    assign a19_s = sync_v[3];
    assign test_n_s = sync_v[4];
    assign osc_s = sync_v[5];

    wire nmi_pend_w;
    crps_edge_latch u_nmi (
        .ref_clk(ref_clk),
        .rst(rst),
        .level_in(nmi_s),
        .ack(nmi_ack),
        .pending(nmi_pend_w)
    );

    // ************************************************
    // Pin drive decode
    // ************************************************
    // Delay pin enable and strobe pass here; the address/data enable applies float mode itself
    function drive_ok;
        input want;
        input float_mode;
        begin
            drive_ok = want & ~float_mode;
        end
    endfunction

    // ************************************************
    // Operating state
    // ************************************************
    localparam [4:0] ST_RESET = 5'h01;
    localparam [4:0] ST_RUN = 5'h02;
    localparam [4:0] ST_HOLD = 5'h04;
    localparam [4:0] ST_PDOWN = 5'h08;
    localparam [4:0] ST_WAKE = 5'h10;

    localparam [2:0] BP_IDLE = 3'h1;
    localparam [2:0] BP_ADDR = 3'h2;
    localparam [2:0] BP_DATA = 3'h4;

    reg [4:0] state_r, state_nxt;
    reg [2:0] bus_r, bus_nxt;
    reg [15:0] wake_cnt_r, wake_cnt_nxt;
    reg float_r, float_nxt;
    reg res_prev_r;
    reg div_r;
    reg osc_prev_r;
    reg bus_wr_r;
    reg [`CRPS_AD_W-1:0] bus_wdata_r;
    reg [`CRPS_AD_W-1:0] ad_hold_r;

    wire in_reset = ~res_n_s;
    wire release_evt = res_n_s & ~res_prev_r;
    wire osc_fall = osc_prev_r & ~osc_s;
    wire [`CRPS_AD_W-1:0] bus_mask = BUS_8BIT ? `CRPS_BUS_8BIT_MASK : {`CRPS_AD_W{1'b1}};

    always @*
    begin
        state_nxt = state_r;
        wake_cnt_nxt = wake_cnt_r;
        float_nxt = float_r;
        case (state_r)
            ST_RESET:
            begin
                // Float mode is strapped while reset is held
                float_nxt = ~a19_s;
                if (release_evt)
                    state_nxt = ST_RUN;
            end
            ST_RUN:
            begin
                if (bus_r == BP_IDLE && powerdown_req)
                    state_nxt = ST_PDOWN;
                else if (bus_r == BP_IDLE && bus_hold_req)
                    state_nxt = ST_HOLD;
            end
            ST_HOLD:
            begin
                if (!bus_hold_req)
                    state_nxt = ST_RUN;
            end
            ST_PDOWN:
            begin
                wake_cnt_nxt = 16'h0000;
                if (wake_req | nmi_pend_w)
                    state_nxt = ST_WAKE;
            end
            ST_WAKE:
            begin
                // Wait both the timer pin and a minimum settle time
                // The settle count also covers the lag of the delay pin sync
                if (wake_cnt_r < PD_SETTLE_CYC[15:0])
                    wake_cnt_nxt = wake_cnt_r + 16'h0001;
                else if (pdt_s)
                    state_nxt = ST_RUN;
            end
            default:
                state_nxt = ST_RESET;
        endcase
        if (in_reset)
            state_nxt = ST_RESET;
    end

    // ************************************************
    // Bus phase sequencer
    // ************************************************
    always @*
    begin
        bus_nxt = bus_r;
        case (bus_r)
            BP_IDLE:
                if (state_r == ST_RUN && core_bus_start && !bus_hold_req && !powerdown_req)
                    bus_nxt = BP_ADDR;
            BP_ADDR:
                bus_nxt = BP_DATA;
            BP_DATA:
                bus_nxt = BP_IDLE;
            default:
                bus_nxt = BP_IDLE;
        endcase
        if (in_reset)
            bus_nxt = BP_IDLE;
    end

    always @(posedge ref_clk)
    begin
        if (rst)
        begin
            state_r <= ST_RESET;
            bus_r <= BP_IDLE;
            wake_cnt_r <= 16'h0000;
            float_r <= 1'b0;
            res_prev_r <= 1'b0;
            div_r <= 1'b0;
            osc_prev_r <= 1'b0;
            bus_wr_r <= 1'b0;
            bus_wdata_r <= {`CRPS_AD_W{1'b0}};
            ad_hold_r <= {`CRPS_AD_W{1'b0}};
        end
        else
        begin
            state_r <= state_nxt;
            bus_r <= bus_nxt;
            wake_cnt_r <= wake_cnt_nxt;
            float_r <= float_nxt;
            res_prev_r <= res_n_s;
            osc_prev_r <= osc_s;
            // Divider runs in every state; release realigns its phase
            if (release_evt)
                div_r <= 1'b0;
            else if (osc_fall)
                div_r <= ~div_r;
            if (bus_r == BP_IDLE && bus_nxt == BP_ADDR)
            begin
                bus_wr_r <= core_bus_write;
                bus_wdata_r <= core_wdata & bus_mask;
            end
            if (muxed_addr_data_oe)
                ad_hold_r <= muxed_addr_data_o;
        end
    end

    // ************************************************
    // Registered pins
    // ************************************************
    always @(posedge ref_clk)
    begin
        if (rst)
        begin
            crystal_drive_out <= 1'b0;
            half_rate_clock_out <= 1'b0;
            reset_indicator_out <= 1'b1;
            powerdown_delay_pin_o <= 1'b0;
            powerdown_delay_pin_oe <= 1'b0;
            muxed_addr_data_o <= {`CRPS_AD_W{1'b0}};
            muxed_addr_data_oe <= 1'b0;
            addr_latch_strobe <= 1'b0;
            core_rdata <= {`CRPS_AD_W{1'b0}};
            core_bus_done <= 1'b0;
            core_run <= 1'b0;
            fetch_addr <= {`CRPS_ADDR_W{1'b0}};
            fetch_start <= 1'b0;
            nmi_pending <= 1'b0;
            nmi_type <= 8'h00;
            pin_float_test_mode <= 1'b0;
        end
        else
        begin
            // Crystal drive never floats, even in float mode
            crystal_drive_out <= ~osc_s;
            // Forcing zero on release realigns the output to the oscillator
            half_rate_clock_out <= release_evt ? 1'b0 : (osc_fall ? ~div_r : div_r);
            reset_indicator_out <= (state_nxt == ST_RESET);
            pin_float_test_mode <= float_nxt & ~in_reset;
            powerdown_delay_pin_o <= (state_nxt == ST_PDOWN);
            powerdown_delay_pin_oe <= drive_ok(state_nxt == ST_PDOWN, float_nxt);
            // The strobe is a pin too, so float mode silences it
            addr_latch_strobe <= drive_ok(bus_nxt == BP_ADDR, float_nxt);
            // A cycle cut by reset gives no done pulse
            core_bus_done <= (bus_r == BP_DATA) && !in_reset;
            if (bus_r == BP_DATA && !bus_wr_r)
                core_rdata <= muxed_addr_data_i & bus_mask;
            if (bus_nxt == BP_ADDR)
            begin
                muxed_addr_data_o <= core_addr[`CRPS_AD_W-1:0] & bus_mask;
                muxed_addr_data_oe <= ~float_nxt;
            end
            else if (bus_nxt == BP_DATA && bus_wr_r)
            begin
                muxed_addr_data_o <= bus_wdata_r;
                muxed_addr_data_oe <= ~float_nxt;
            end
            else if (state_nxt == ST_PDOWN)
            begin
                // Keep last level on the output through powerdown; the enable stays low
                muxed_addr_data_o <= ad_hold_r;
                muxed_addr_data_oe <= muxed_addr_data_oe & ~float_nxt;
            end
            else
                muxed_addr_data_oe <= 1'b0;
            core_run <= (state_nxt == ST_RUN) && !(core_wait_instr && test_n_s);
            // Fetch restarts from the vector on every release, first or later
            fetch_start <= release_evt;
            if (release_evt)
                fetch_addr <= `CRPS_RESET_VECTOR;
            nmi_pending <= nmi_pend_w & ~in_reset;
            nmi_type <= `CRPS_NMI_TYPE;
        end
    end
endmodule // crps_ctrl
`default_nettype wire

// ==== tb/crps_partner.sv ====
// Far-side model: oscillator, bus device and powerdown delay capacitor.
// Assumes the controller samples every pin on ref_clk.
`timescale 1ns/1ns
`default_nettype none
module crps_partner (
    input wire logic ref_clk,
    input wire logic muxed_addr_data_oe,
    input wire logic addr_latch_strobe,
    input wire logic powerdown_delay_pin_o,
    input wire logic powerdown_delay_pin_oe,
    input wire logic [15:0] reply,
    output var logic osc_input,
    output var logic [15:0] muxed_addr_data_i,
    output var logic powerdown_delay_pin_i
);
    logic [2:0] osc_cnt = 3'h0;
    logic [1:0] ph_r = 2'h0;
    logic [1:0] cap_cnt = 2'h0;
    logic [15:0] last_r = 16'h0;
    initial osc_input = 1'b1;
    // Slow oscillator so each level is seen on several ref_clk edges
    always @(negedge ref_clk)
    begin
        osc_cnt <= osc_cnt + 3'h1;
        if (osc_cnt[1:0] == 2'h3)
            osc_input <= ~osc_input;
    end
    always @(posedge ref_clk)
    begin
        ph_r <= {ph_r[0], addr_latch_strobe};
        last_r <= muxed_addr_data_i;
        if (powerdown_delay_pin_oe)
            cap_cnt <= 2'h0;
        else if (cap_cnt != 2'h3)
            cap_cnt <= cap_cnt + 2'h1;
    end
    // Released bus shows a changing pattern, never a stale value
    always @*
        muxed_addr_data_i = (|ph_r && !muxed_addr_data_oe) ? reply : ~last_r;
    always @*
        powerdown_delay_pin_i = powerdown_delay_pin_oe ? powerdown_delay_pin_o : (cap_cnt == 2'h3);
endmodule // crps_partner
`default_nettype wire

// ==== tb/crps_ctrl_chk.sv ====
// Port-level checker for the clock, reset and pin-state controller.
// Assumes 16-bit bus unless BUS_8BIT is handed on by the bind.
`timescale 1ns/1ns
`default_nettype none
`include "crps_consts.vh"
module crps_ctrl_chk #(
    parameter BUS_8BIT = 0
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic osc_input,
    input wire logic crystal_drive_out,
    input wire logic half_rate_clock_out,
    input wire logic reset_request_in_n,
    input wire logic reset_indicator_out,
    input wire logic nmi_in,
    input wire logic powerdown_delay_pin_o,
    input wire logic powerdown_delay_pin_oe,
    input wire logic [15:0] muxed_addr_data_o,
    input wire logic muxed_addr_data_oe,
    input wire logic addr_latch_strobe,
    input wire logic bus_hold_req,
    input wire logic [19:0] core_addr,
    input wire logic core_bus_done,
    input wire logic [19:0] fetch_addr,
    input wire logic fetch_start,
    input wire logic nmi_pending,
    input wire logic [7:0] nmi_type,
    input wire logic pin_float_test_mode
);
    localparam logic [15:0] MSK = BUS_8BIT ? 16'h00FF : 16'hFFFF;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    // ************
    // Assertions
    // ************
    xtal_runs_a: assert property (!$past(rst, 3) |-> crystal_drive_out == !$past(osc_input, 3))
        else $error("crystal output not following oscillator");
    half_quiet_a: assert property ($past(osc_input, 4) && $past(osc_input, 3) && !$past(rst, 4)
        && !reset_indicator_out && !$past(reset_indicator_out) |-> $stable(half_rate_clock_out))
        else $error("clock output moved without oscillator fall");
    rst_enter_a: assert property (!reset_request_in_n [*4] |-> reset_indicator_out)
        else $error("reset indicator late");
    rst_leave_a: assert property ($rose(reset_request_in_n) |-> ##[1:6] !reset_indicator_out)
        else $error("reset indicator stuck");
    fetch_vec_a: assert property ($fell(reset_indicator_out) |-> ##[0:2]
        (fetch_start && fetch_addr == `CRPS_RESET_VECTOR))
        else $error("no fetch at reset vector");
    rst_float_a: assert property (reset_indicator_out |-> !muxed_addr_data_oe
        && !powerdown_delay_pin_oe && !addr_latch_strobe)
        else $error("pin driven during reset");
    pd_drive_a: assert property (powerdown_delay_pin_oe |-> powerdown_delay_pin_o
        && !reset_indicator_out)
        else $error("powerdown pin levels wrong");
    pd_retain_a: assert property (powerdown_delay_pin_oe && $past(powerdown_delay_pin_oe)
        |-> $stable(muxed_addr_data_o))
        else $error("bus changed in powerdown");
    hold_float_a: assert property (bus_hold_req [*6] |-> !muxed_addr_data_oe)
        else $error("bus driven during hold");
    addr_phase_a: assert property (addr_latch_strobe |-> muxed_addr_data_oe
        && muxed_addr_data_o == ($past(core_addr[15:0]) & MSK)
        ##2 (core_bus_done || reset_indicator_out))
        else $error("address phase wrong");
    float_mode_a: assert property (pin_float_test_mode |-> !muxed_addr_data_oe
        && !powerdown_delay_pin_oe && !addr_latch_strobe)
        else $error("pin driven in float mode");
    nmi_latch_a: assert property ($rose(nmi_in) && !reset_indicator_out |-> ##[1:5] nmi_pending)
        else $error("interrupt edge lost");
    nmi_type_a: assert property (nmi_pending |-> nmi_type == `CRPS_NMI_TYPE)
        else $error("interrupt type wrong");
    c_fetch: cover property (fetch_start);
    c_cycle: cover property (addr_latch_strobe ##2 core_bus_done);
    c_pd: cover property (powerdown_delay_pin_oe);
    c_float: cover property (pin_float_test_mode);
endmodule // crps_ctrl_chk
bind crps_ctrl crps_ctrl_chk #(.BUS_8BIT(BUS_8BIT)) u_crps_ctrl_chk (.*);
`default_nettype wire

// ==== tb/crps_ctrl_test.sv ====
// Self-checking bench for the controller; bench drives reset pin and test select.
// Assumes the partner model supplies oscillator, bus replies and delay pin.
`timescale 1ns/1ns
`default_nettype none
module crps_ctrl_test;
    logic ref_clk = 1'b0, rst = 1'b1, reset_request_in_n = 1'b0, nmi_in = 1'b0;
    logic wait_test_in_n = 1'b1, upper_addr_test_select = 1'b1, bus_hold_req = 1'b0;
    logic powerdown_req = 1'b0, wake_req = 1'b0, core_bus_start = 1'b0, core_bus_write = 1'b0;
    logic core_wait_instr = 1'b0, nmi_ack = 1'b0, h;
    logic [19:0] core_addr = 20'h0, fetch_addr;
    logic [15:0] core_wdata = 16'h0, reply = 16'h0, v = 16'hDC5E;
    logic [15:0] muxed_addr_data_i, muxed_addr_data_o, core_rdata;
    logic osc_input, crystal_drive_out, half_rate_clock_out, reset_indicator_out;
    logic powerdown_delay_pin_i, powerdown_delay_pin_o, powerdown_delay_pin_oe;
    logic muxed_addr_data_oe, addr_latch_strobe, core_bus_done, core_run, fetch_start;
    logic nmi_pending, pin_float_test_mode;
    logic [7:0] nmi_type;
    int err_total = 0, compares = 0, n;
    crps_ctrl #(.PD_SETTLE_CYC(2)) u_crps_ctrl (.*);
    crps_partner u_crps_partner (.*);
    always #20 ref_clk = ~ref_clk;
    // ************
    // Helpers
    // ************
    function automatic logic [15:0] lfsr(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction
    function automatic int toggles(input int cyc);
        return cyc / 8;
    endfunction
    task tick;
        @(posedge ref_clk);
        #1;
    endtask
    task step;
        tick;
        n++;
    endtask
    task chk(input logic [19:0] seen, input logic [19:0] exp);
        compares++;
        if (seen !== exp)
        begin
            err_total++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task report_and_stop;
        $display("compares=%0d err_total=%0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task do_reset(input logic sel);
        reset_request_in_n = 1'b0;
        upper_addr_test_select = sel;
        repeat (6) tick;
        chk(reset_indicator_out, 1'b1);
        chk(muxed_addr_data_oe, 1'b0);
        reset_request_in_n = 1'b1;
        n = 0;
        while (fetch_start !== 1'b1 && n < 30) step;
        upper_addr_test_select = 1'b1;
        chk(fetch_addr, 20'hFFFF0);
        repeat (3) tick;
        chk(reset_indicator_out, 1'b0);
    endtask
    // Start is held until the strobe shows it was taken
    task bus(input logic w, input logic [19:0] a, input logic [15:0] d);
        core_bus_start = 1'b1;
        core_bus_write = w;
        core_addr = a;
        core_wdata = d;
        n = 0;
        while (addr_latch_strobe !== 1'b1 && n < 20) step;
        core_bus_start = 1'b0;
        chk(muxed_addr_data_o, a[15:0]);
        tick;
        if (w)
            chk(muxed_addr_data_o, d);
        tick;
        chk(core_bus_done, 1'b1);
        if (!w)
            chk(core_rdata, reply);
    endtask
    // ************
    // Sequence
    // ************
    initial
    begin
        #(40 * 5000);
        err_total++;
        report_and_stop;
    end
    initial
    begin
        repeat (4) tick;
        rst = 1'b0;
        do_reset(1'b1);
        chk(core_run, 1'b1);
        n = 0;
        repeat (32)
        begin
            h = half_rate_clock_out;
            tick;
            n += int'(h !== half_rate_clock_out);
        end
        chk(n, toggles(32));
        $display("reset and clock done");
        bus(1'b1, 20'hFFFFF, 16'hFFFF);
        reply = 16'hFFFF;
        bus(1'b0, 20'h00000, 16'h0000);
        for (int i = 0; i < 16; i++)
        begin
            v = lfsr(v);
            reply = ~v;
            bus(v[0], {v[3:0], v}, v ^ 16'h5A5A);
        end
        $display("bus cycles done");
        bus_hold_req = 1'b1;
        repeat (6) tick;
        chk(muxed_addr_data_oe, 1'b0);
        chk(reset_indicator_out, 1'b0);
        bus_hold_req = 1'b0;
        powerdown_req = 1'b1;
        repeat (4) tick;
        chk(powerdown_delay_pin_oe, 1'b1);
        chk(powerdown_delay_pin_o, 1'b1);
        chk(reset_indicator_out, 1'b0);
        powerdown_req = 1'b0;
        wake_req = 1'b1;
        tick;
        wake_req = 1'b0;
        n = 0;
        while (core_run !== 1'b1 && n < 40) step;
        chk(core_run, 1'b1);
        $display("hold and powerdown done");
        nmi_in = 1'b1;
        n = 0;
        while (nmi_pending !== 1'b1 && n < 10) step;
        chk(nmi_type, 8'h02);
        nmi_ack = 1'b1;
        tick;
        nmi_ack = 1'b0;
        nmi_in = 1'b0;
        tick;
        chk(nmi_pending, 1'b0);
        core_wait_instr = 1'b1;
        repeat (5) tick;
        chk(core_run, 1'b0);
        wait_test_in_n = 1'b0;
        repeat (5) tick;
        chk(core_run, 1'b1);
        core_wait_instr = 1'b0;
        wait_test_in_n = 1'b1;
        $display("interrupt and wait done");
        // Reset lands in the data phase of a write: no done pulse
        reset_request_in_n = 1'b0;
        core_bus_start = 1'b1;
        core_bus_write = 1'b1;
        tick;
        core_bus_start = 1'b0;
        repeat (2) tick;
        chk(core_bus_done, 1'b0);
        chk(reset_indicator_out, 1'b1);
        do_reset(1'b1);
        do_reset(1'b0);
        chk(pin_float_test_mode, 1'b1);
        core_bus_start = 1'b1;
        repeat (4) tick;
        core_bus_start = 1'b0;
        chk(muxed_addr_data_oe, 1'b0);
        do_reset(1'b1);
        chk(pin_float_test_mode, 1'b0);
        $display("abort and float done");
        report_and_stop;
    end
endmodule // crps_ctrl_test
`default_nettype wire
